/* File: src/axis_aux_control.sv */
// Per-axis auxiliary control: filters, sensor, sync start, queue, irq
`include "axis_aux_defines.svh"
//
// Overview of operation
// - Axis raises interrupt on drive end, queue state, or compare match.
// - Reservation queue holds up to ten pending drive commands.
// - Queued commands issue in stored order as each drive completes.
// - Plus and minus limit polarity can be inverted by configuration.
// - Time constant applies to limits, done, origin, proximity, index inputs.
// - Aux sensor can stop drive, latch counter, or trigger drive change.
// - Sensor source: dedicated input, general input, or any axis status.
// - General output carries compare result, axis status, or counter output.
// - Axis can wait and start on sensor, input, axis status, pause release.
// - Host reads live status, settings and latch data at any time.
// - Limits and emergency stop default to break-contact polarity at reset.
// - General purpose input used as driver alarm can be inverted.
// - Dedicated sensor functions ignored in manual mode, honoured in bus mode.
// - Latch captures counter at event, holds it, optionally clears counter.
module axis_aux_control
  import axis_aux_pkg::*;
#(
  parameter int NUM_AXES = 12,
  parameter int QDEPTH = 10,
  parameter int CW = 32
) (
  input wire logic clk, // 250 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire axis_aux_pkg::apb_addr_t paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic plusLimitIn, // plus limit pin
  input wire logic minusLimitIn, // minus limit pin
  input wire logic emergencyStopIn, // emergency stop pin
  input wire logic positioningDoneIn, // positioning done pin
  input wire logic originIn, // origin pin
  input wire logic originProximityIn, // origin proximity pin
  input wire logic encoderIndexPosIn, // encoder index, positive
  input wire logic encoderIndexNegIn, // encoder index, negative
  input wire logic auxSensorIn, // dedicated sensor pin
  input wire logic generalInput, // general input pin
  input wire logic generalPurposeIn, // general purpose input pin
  input wire logic manualMode, // 1 manual mode, 0 bus mode
  input wire logic [NUM_AXES-1:0] axisStatus, // status of every axis
  input wire logic driveDone, // drive end pulse
  input wire logic compareMatch, // counter compare match pulse
  input wire logic compareResult, // compare register result level
  input wire logic counterOut, // counter output level
  input wire logic [CW-1:0] counterValue, // live counter value
  input wire logic cmdReady, // drive engine takes a command
  output logic cmdValid, // queued command available
  output axis_aux_pkg::cmd_word_t cmdData, // head queued command
  output logic plusLimit, // plus limit asserted
  output logic minusLimit, // minus limit asserted
  output logic emergencyStop, // emergency stop asserted
  output logic driverAlarm, // driver alarm asserted
  output logic [4:0] filteredAux, // done, origin, prox, index+/-
  output logic sensorStop, // stop drive pulse
  output logic sensorChange, // drive change trigger pulse
  output logic counterClear, // counter clear pulse
  output logic syncStart, // synchronized start pulse
  output logic generalOutput, // general output pin
  output logic irq // interrupt, active high level
);
  // ========================================================
  // Registers and wires
  logic [4:0] ctrl_q;
  logic [15:0] filterTc_q;
  logic [11:0] sensorCfg_q;
  logic [7:0] outCfg_q;
  logic [7:0] syncCfg_q;
  logic [`IRQ_WIDTH-1:0] irqStat_q;
  logic [`IRQ_WIDTH-1:0] irqEn_q;
  logic [CW-1:0] latch_q;
  logic sensorSig_q;
  logic sensorEvt_q;
  logic generalOutput_q;
  sync_state_e syncState_q;
  logic [6:0] filtRaw;
  logic [6:0] filtOut;
  logic apbWr;
  logic apbRd;
  logic mapped;
  logic [`IRQ_WIDTH-1:0] irqEvt;
  logic sensorSel;
  logic sensorRise;
  logic sensorFnEn;
  logic syncCond;
  logic pauseRelease;
  logic selAxisSensor;
  logic selAxisOut;
  logic selAxisSync;
  logic [31:0] statusWord;

  cmd_q_if #(.DEPTH(QDEPTH), .W(32)) q ();

  // ========================================================
  // Input filtering and polarity
  assign filtRaw = {encoderIndexNegIn, encoderIndexPosIn, originProximityIn,
                    originIn, positioningDoneIn, minusLimitIn, plusLimitIn};

  input_filter #(.W(7), .CW(16), .INIT(`FILTER_INIT)) u_filter (
    .clk(clk),
    .reset_n(reset_n),
    .tc(filterTc_q),
    .raw(filtRaw),
    .filt(filtOut)
  );

  assign plusLimit = filtOut[0] ^ ctrl_q[`CTRL_PLUS_INV];
  assign minusLimit = filtOut[1] ^ ctrl_q[`CTRL_MINUS_INV];
  assign emergencyStop = emergencyStopIn ^ ctrl_q[`CTRL_ESTOP_INV];
  assign driverAlarm = ctrl_q[`CTRL_ALARM_EN] &
                       (generalPurposeIn ^ ctrl_q[`CTRL_ALARM_INV]);
  assign filteredAux = filtOut[6:2];

  // ========================================================
  // Axis status selection
  always_comb begin
    selAxisSensor = 1'b0;
    selAxisOut = 1'b0;
    selAxisSync = 1'b0;
    if (int'(sensorCfg_q[7:4]) < NUM_AXES) begin
      selAxisSensor = axisStatus[sensorCfg_q[7:4]];
    end
    if (int'(outCfg_q[7:4]) < NUM_AXES) begin
      selAxisOut = axisStatus[outCfg_q[7:4]];
    end
    if (int'(syncCfg_q[7:4]) < NUM_AXES) begin
      selAxisSync = axisStatus[syncCfg_q[7:4]];
    end
  end

  // ========================================================
  // Multipurpose sensor
  always_comb begin
    case (sensorCfg_q[1:0])
      `SRC_DEDICATED: sensorSel = auxSensorIn;
      `SRC_GENERAL: sensorSel = generalInput;
      `SRC_AXIS: sensorSel = selAxisSensor;
      default: sensorSel = 1'b0;
    endcase
  end

  assign sensorFnEn = !(manualMode &&
                        sensorCfg_q[1:0] == `SRC_DEDICATED);
  assign sensorRise = sensorSel && !sensorSig_q && sensorFnEn;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sensorSig_q <= 1'b0;
      sensorEvt_q <= 1'b0;
    end else begin
      sensorSig_q <= sensorSel;
      sensorEvt_q <= sensorRise;
    end
  end

  assign sensorStop = sensorEvt_q && sensorCfg_q[`SEN_STOP_EN];
  assign sensorChange = sensorEvt_q && sensorCfg_q[`SEN_CHANGE_EN];

  // Latch holds until the next latch event
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_q <= '0;
    end else if (sensorRise && sensorCfg_q[`SEN_LATCH_EN]) begin
      latch_q <= counterValue;
    end
  end

  assign counterClear = sensorEvt_q && sensorCfg_q[`SEN_LATCH_EN] &&
                        sensorCfg_q[`SEN_LCLR_EN];

  // ========================================================
  // General output routing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      generalOutput_q <= 1'b0;
    end else begin
      case (outCfg_q[1:0])
        `GOUT_COMPARE: generalOutput_q <= compareResult;
        `GOUT_STATUS: generalOutput_q <= selAxisOut;
        `GOUT_COUNTER: generalOutput_q <= counterOut;
        default: generalOutput_q <= 1'b0;
      endcase
    end
  end

  assign generalOutput = generalOutput_q;

  // ========================================================
  // Synchronized start
  assign pauseRelease = apbWr && paddr == `OFS_PAUSE && pwdata[0];

  always_comb begin
    case (syncCfg_q[2:0])
      `SYNC_NONE: syncCond = 1'b1;
      `SYNC_SENSOR: syncCond = auxSensorIn;
      `SYNC_GENERAL: syncCond = generalInput;
      `SYNC_AXIS: syncCond = selAxisSync;
      `SYNC_PAUSE: syncCond = pauseRelease;
      default: syncCond = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncState_q <= SYNC_IDLE;
      syncStart <= 1'b0;
    end else begin
      syncStart <= 1'b0;
      case (syncState_q)
        SYNC_IDLE: begin
          if (apbWr && paddr == `OFS_SYNC_CFG && pwdata[`SYNC_ARM_BIT]) begin
            syncState_q <= SYNC_WAIT;
          end
        end
        SYNC_WAIT: begin
          if (syncCond) begin
            syncStart <= 1'b1;
            syncState_q <= SYNC_IDLE;
          end
        end
        default: syncState_q <= SYNC_IDLE;
      endcase
    end
  end

  // ========================================================
  // Reservation queue
  assign q.push = apbWr && paddr == `OFS_CMD;
  assign q.pushData = pwdata;
  assign q.pop = cmdReady;
  assign cmdValid = !q.empty;
  assign cmdData = q.popData;

  cmd_queue #(.DEPTH(QDEPTH), .W(32)) u_queue (
    .clk(clk),
    .reset_n(reset_n),
    .q(q.queue)
  );

  // ========================================================
  // Interrupts
  always_comb begin
    irqEvt = '0;
    irqEvt[`IRQ_DRIVE_END] = driveDone;
    irqEvt[`IRQ_QUEUE] = cmdReady && cmdValid && q.count == 1;
    irqEvt[`IRQ_COMPARE] = compareMatch;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= (irqStat_q & ~((apbWr && paddr == `OFS_IRQ_CLR) ?
                   pwdata[`IRQ_WIDTH-1:0] : '0)) | irqEvt;
    end
  end

  assign irq = |(irqStat_q & irqEn_q);

  // ========================================================
  // APB slave, zero wait states
  assign pready = 1'b1;
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && penable && !pwrite;

  always_comb begin
    case (paddr)
      `OFS_CTRL, `OFS_FILTER, `OFS_SENSOR_CFG, `OFS_OUT_CFG, `OFS_SYNC_CFG,
      `OFS_CMD, `OFS_STATUS, `OFS_LATCH, `OFS_IRQ_STAT, `OFS_IRQ_CLR,
      `OFS_IRQ_EN, `OFS_PAUSE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && (!mapped ||
                   (pwrite && paddr == `OFS_CMD && q.full));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `CTRL_RESET;
      filterTc_q <= `FILTER_RESET;
      sensorCfg_q <= '0;
      outCfg_q <= '0;
      syncCfg_q <= '0;
      irqEn_q <= '0;
    end else if (apbWr) begin
      case (paddr)
        `OFS_CTRL: ctrl_q <= pwdata[4:0];
        `OFS_FILTER: filterTc_q <= pwdata[15:0];
        `OFS_SENSOR_CFG: sensorCfg_q <= pwdata[11:0];
        `OFS_OUT_CFG: outCfg_q <= pwdata[7:0];
        `OFS_SYNC_CFG: syncCfg_q <= pwdata[7:0];
        `OFS_IRQ_EN: irqEn_q <= pwdata[`IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    statusWord = '0;
    statusWord[6:0] = {filteredAux, minusLimit, plusLimit};
    statusWord[7] = emergencyStop;
    statusWord[8] = driverAlarm;
    statusWord[9] = sensorSel;
    statusWord[10] = syncState_q == SYNC_WAIT;
    statusWord[11] = q.full;
    statusWord[12] = q.empty;
    statusWord[19:16] = 4'(q.count);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFS_CTRL: prdata <= {27'h0, ctrl_q};
        `OFS_FILTER: prdata <= {16'h0, filterTc_q};
        `OFS_SENSOR_CFG: prdata <= {20'h0, sensorCfg_q};
        `OFS_OUT_CFG: prdata <= {24'h0, outCfg_q};
        `OFS_SYNC_CFG: prdata <= {24'h0, syncCfg_q};
        `OFS_STATUS: prdata <= statusWord;
        `OFS_LATCH: prdata <= 32'(latch_q);
        `OFS_IRQ_STAT: prdata <= {29'h0, irqStat_q};
        `OFS_IRQ_EN: prdata <= {29'h0, irqEn_q};
        default: prdata <= '0;
      endcase
    end
  end
endmodule // axis_aux_control

/* File: src/axis_aux_defines.svh */
// Register offsets, field positions, reset values for the axis aux block
`ifndef AXIS_AUX_DEFINES_SVH
`define AXIS_AUX_DEFINES_SVH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_CTRL       8'h00
`define OFS_FILTER     8'h04
`define OFS_SENSOR_CFG 8'h08
`define OFS_OUT_CFG    8'h0c
`define OFS_SYNC_CFG   8'h10
`define OFS_CMD        8'h14
`define OFS_STATUS     8'h18
`define OFS_LATCH      8'h1c
`define OFS_IRQ_STAT   8'h20
`define OFS_IRQ_CLR    8'h24
`define OFS_IRQ_EN     8'h28
`define OFS_PAUSE      8'h2c

// ==========================================================
// Control fields
`define CTRL_PLUS_INV  0
`define CTRL_MINUS_INV 1
`define CTRL_ESTOP_INV 2
`define CTRL_ALARM_INV 3
`define CTRL_ALARM_EN  4
`define CTRL_RESET     5'h00

// Sensor configuration fields
`define SRC_DEDICATED  2'h0
`define SRC_GENERAL    2'h1
`define SRC_AXIS       2'h2
`define SEN_STOP_EN    8
`define SEN_LATCH_EN   9
`define SEN_CHANGE_EN  10
`define SEN_LCLR_EN    11

// General output selection
`define GOUT_COMPARE   2'h0
`define GOUT_STATUS    2'h1
`define GOUT_COUNTER   2'h2

// Synchronized start sources
`define SYNC_NONE      3'h0
`define SYNC_SENSOR    3'h1
`define SYNC_GENERAL   3'h2
`define SYNC_AXIS      3'h3
`define SYNC_PAUSE     3'h4
`define SYNC_ARM_BIT   8

// Interrupt event bits
`define IRQ_DRIVE_END  0
`define IRQ_QUEUE      1
`define IRQ_COMPARE    2
`define IRQ_WIDTH      3

// Filter time constant reset value, in sampling clocks
`define FILTER_RESET   16'h0000
// Filter reset levels: both limits start asserted
`define FILTER_INIT    7'h03

`endif

/* File: src/axis_aux_pkg.sv */
// Types shared by the axis aux block
package axis_aux_pkg;
  typedef enum logic {SYNC_IDLE, SYNC_WAIT} sync_state_e;
  typedef logic [31:0] cmd_word_t;
  typedef logic [7:0] apb_addr_t;
endpackage

/* File: src/cmd_q_if.sv */
// Carrier between the axis logic and its reservation queue
interface cmd_q_if #(parameter int DEPTH = 10, parameter int W = 32);
  logic push;
  logic [W-1:0] pushData;
  logic full;
  logic pop;
  logic [W-1:0] popData;
  logic empty;
  logic [$clog2(DEPTH+1)-1:0] count;
  modport user (output push, output pushData, output pop,
                input full, input popData, input empty, input count);
  modport queue (input push, input pushData, input pop,
                 output full, output popData, output empty, output count);
endinterface

/* File: src/cmd_queue.sv */
// Reservation queue for drive commands
module cmd_queue #(
  parameter int DEPTH = 10,
  parameter int W = 32
) (
  input wire logic clk, // clock
  input wire logic reset_n, // async reset, active low
  cmd_q_if.queue q // queue port
);
  localparam int PW = $clog2(DEPTH);
  localparam int CNTW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [$clog2(DEPTH+1)-1:0] count_q;
  logic doPush;
  logic doPop;

  assign doPush = q.push && !q.full;
  assign doPop = q.pop && !q.empty;
  assign q.full = (count_q == DEPTH[$clog2(DEPTH+1)-1:0]);
  assign q.empty = (count_q == '0);
  assign q.count = count_q;
  assign q.popData = mem[rdPtr_q];

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_q] <= q.pushData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doPush) begin
        wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (doPop) begin
        rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + CNTW'(doPush) - CNTW'(doPop);
    end
  end
endmodule // cmd_queue

/* File: src/input_filter.sv */
// Per-bit input time-constant filter
`include "axis_aux_defines.svh"
module input_filter #(
  parameter int W = 7,
  parameter int CW = 16,
  parameter logic [W-1:0] INIT = `FILTER_INIT
) (
  input wire logic clk, // clock
  input wire logic reset_n, // async reset, active low
  input wire logic [CW-1:0] tc, // stable cycles required, minus one
  input wire logic [W-1:0] raw, // unfiltered inputs
  output logic [W-1:0] filt // filtered levels
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic [CW-1:0] cnt_q;
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          cnt_q <= '0;
          filt[i] <= INIT[i];
        end else if (raw[i] == filt[i]) begin
          cnt_q <= '0;
        end else if (cnt_q >= tc) begin
          cnt_q <= '0;
          filt[i] <= raw[i];
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  endgenerate
endmodule // input_filter

/* File: verif/axis_aux_control_sva.sv */
// Port-level checker for the axis aux control block
`include "axis_aux_defines.svh"
module axis_aux_control_sva
  import axis_aux_pkg::*;
(
  input wire logic clk, // clock
  input wire logic reset_n, // async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire axis_aux_pkg::apb_addr_t paddr, // APB address
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic emergencyStopIn, // raw stop pin
  input wire logic emergencyStop, // stop asserted
  input wire logic positioningDoneIn, // raw done pin
  input wire logic [4:0] filteredAux, // filtered aux levels
  input wire logic cmdReady, // engine takes command
  input wire logic cmdValid, // queue not empty
  input wire logic syncStart, // start pulse
  input wire logic sensorStop, // stop pulse
  input wire logic irq // interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Bus answers
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_unmapped_err: assert property (psel && penable &&
    (paddr > `OFS_PAUSE || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (psel && penable && paddr <= `OFS_PAUSE
    && paddr[1:0] == 2'h0 && !(pwrite && paddr == `OFS_CMD) |-> !pslverr)
    else $error("mapped access flagged as error");
  a_wo_zero: assert property (psel && penable && !pwrite &&
    (paddr == `OFS_CMD || paddr == `OFS_IRQ_CLR) |-> prdata == 32'h0)
    else $error("write-only register read nonzero");
  // ==========================================================
  // Pins, queue and events
  a_irq_fall: assert property ($fell(irq) |->
    $past(psel && penable && pwrite))
    else $error("interrupt dropped without a write");
  a_estop_cause: assert property ($changed(emergencyStop) |->
    $changed(emergencyStopIn) ||
    $past(psel && penable && pwrite && paddr == `OFS_CTRL))
    else $error("stop output moved without cause");
  a_filter_level: assert property ($changed(filteredAux[0]) |->
    filteredAux[0] == $past(positioningDoneIn))
    else $error("filtered level differs from input");
  a_pop_only: assert property ($fell(cmdValid) |-> $past(cmdReady))
    else $error("queue emptied without a pop");
  a_sync_pulse: assert property (syncStart |=> !syncStart)
    else $error("start pulse longer than one cycle");
  a_stop_pulse: assert property (sensorStop |=> !sensorStop)
    else $error("stop pulse longer than one cycle");
endmodule // axis_aux_control_sva

/* File: verif/drive_engine_model.sv */
// Drive engine stand-in: takes queued commands and runs each
module drive_engine_model
  import axis_aux_pkg::*;
#(
  parameter int DUR = 6
) (
  input wire logic clk, // clock
  input wire logic reset_n, // async reset, active low
  input wire logic cmdValid, // queued command available
  input wire axis_aux_pkg::cmd_word_t cmdData, // head command
  input wire logic stall, // hold off taking commands
  output logic cmdReady, // takes head command
  output logic driveDone // drive end pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  cmd_word_t got[$];
  int busy;
  // ==========================================================
  // One command per drive, kept in arrival order
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmdReady <= 1'b0;
      driveDone <= 1'b0;
      busy <= 0;
    end else begin
      driveDone <= 1'b0;
      if (cmdReady) begin
        got.push_back(cmdData);
        cmdReady <= 1'b0;
        busy <= DUR;
      end else if (busy != 0) begin
        busy <= busy - 1;
        driveDone <= (busy == 1);
      end else if (cmdValid && !stall) begin
        cmdReady <= 1'b1;
      end
    end
  end
endmodule // drive_engine_model

/* File: verif/tb_top.sv */
// Self-checking bench for the axis aux control block
`include "axis_aux_defines.svh"
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("Error at %0t: got %h exp %h", $time, (g), (e)); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, counterValue = 0, rdat, prdata, cmdData;
  logic plusLimitIn = 1, minusLimitIn = 1, emergencyStopIn = 1;
  logic positioningDoneIn = 0, originIn = 0, originProximityIn = 0;
  logic encoderIndexPosIn = 0, encoderIndexNegIn = 0, auxSensorIn = 0;
  logic generalInput = 0, generalPurposeIn = 0, manualMode = 0;
  logic [11:0] axisStatus = 0;
  logic compareMatch = 0, compareResult = 0, counterOut = 0, stall = 1;
  logic pready, pslverr, cmdReady, cmdValid, driveDone, plusLimit;
  logic minusLimit, emergencyStop, driverAlarm, sensorStop, sensorChange;
  logic counterClear, syncStart, generalOutput, irq;
  logic [4:0] filteredAux;
  int n_fail = 0, tests_run = 0, nStop = 0, nChg = 0, nClr = 0;
  int nSync = 0, i, j;

  always #2 clk = ~clk;
  always @(posedge clk) begin
    nStop += sensorStop;
    nChg += sensorChange;
    nClr += counterClear;
    nSync += syncStart;
  end

  axis_aux_control dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .plusLimitIn, .minusLimitIn,
    .emergencyStopIn, .positioningDoneIn, .originIn, .originProximityIn,
    .encoderIndexPosIn, .encoderIndexNegIn, .auxSensorIn, .generalInput,
    .generalPurposeIn, .manualMode, .axisStatus, .driveDone, .compareMatch,
    .compareResult, .counterOut, .counterValue, .cmdReady, .cmdValid,
    .cmdData, .plusLimit, .minusLimit, .emergencyStop, .driverAlarm,
    .filteredAux, .sensorStop, .sensorChange, .counterClear, .syncStart,
    .generalOutput, .irq);
  drive_engine_model eng (.clk, .reset_n, .cmdValid, .cmdData, .stall,
    .cmdReady, .driveDone);

  // ==========================================================
  // Helpers
  task automatic end_sim();
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    rdat = prdata;
    `CHK(pslverr, e)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    cyc(2);
    reset_n <= 1'b1;
    @(posedge clk);
    `CHK({plusLimit, minusLimit, emergencyStop, irq}, 4'he)
    acc(0, `OFS_CTRL, 0, 0);
    `CHK(rdat, 32'h0)
    acc(0, `OFS_STATUS, 0, 0);
    `CHK(rdat[12:0], 13'h1083)
    acc(1, `OFS_FILTER, 3, 0);
    acc(1, `OFS_CTRL, 32'h7, 0);
    cyc(8);
    `CHK({plusLimit, minusLimit, emergencyStop}, 3'h0)
    plusLimitIn <= 1'b0;
    cyc(2);
    plusLimitIn <= 1'b1;
    cyc(8);
    `CHK(plusLimit, 1'b0)
    plusLimitIn <= 1'b0;
    cyc(8);
    `CHK(plusLimit, 1'b1)
    {encoderIndexNegIn, encoderIndexPosIn, originProximityIn, originIn,
      positioningDoneIn} <= 5'h15;
    cyc(2);
    `CHK(filteredAux, 5'h00)
    cyc(8);
    `CHK(filteredAux, 5'h15)
    {encoderIndexNegIn, encoderIndexPosIn, originProximityIn, originIn,
      positioningDoneIn} <= 5'h0a;
    cyc(10);
    `CHK(filteredAux, 5'h0a)
    generalPurposeIn <= 1'b1;
    acc(1, `OFS_CTRL, 32'h10, 0);
    `CHK(driverAlarm, 1'b1)
    acc(1, `OFS_CTRL, 32'h18, 0);
    `CHK(driverAlarm, 1'b0)
    acc(1, `OFS_IRQ_EN, 32'h3, 0);
    for (i = 0; i < 10; i++)
      acc(1, `OFS_CMD, 32'h100 + i, 0);
    acc(1, `OFS_CMD, 32'h1ff, 1);
    acc(0, `OFS_STATUS, 0, 0);
    `CHK({rdat[19:16], rdat[12:11]}, 6'h29)
    acc(0, `OFS_CMD, 0, 0);
    `CHK(rdat, 32'h0)
    stall <= 1'b0;
    for (i = 0; i < 500 && eng.got.size() < 10; i++)
      @(posedge clk);
    if (eng.got.size() < 10) begin
      n_fail++;
      end_sim();
    end
    cyc(12);
    `CHK(eng.got.size(), 10)
    for (i = 0; i < 10; i++)
      `CHK(eng.got[i], 32'h100 + i)
    `CHK(irq, 1'b1)
    acc(0, `OFS_IRQ_STAT, 0, 0);
    `CHK(rdat[2:0], 3'h3)
    acc(1, `OFS_IRQ_CLR, 32'h7, 0);
    `CHK(irq, 1'b0)
    compareMatch <= 1'b1;
    @(posedge clk);
    compareMatch <= 1'b0;
    cyc(2);
    `CHK(irq, 1'b0)
    acc(1, `OFS_IRQ_EN, 32'h4, 0);
    `CHK(irq, 1'b1)
    counterValue <= 32'h1234_5678;
    manualMode <= 1'b1;
    acc(1, `OFS_SENSOR_CFG, 32'hf00, 0);
    auxSensorIn <= 1'b1;
    cyc(4);
    `CHK(nStop, 0)
    auxSensorIn <= 1'b0;
    manualMode <= 1'b0;
    cyc(2);
    auxSensorIn <= 1'b1;
    cyc(4);
    `CHK({nStop[3:0], nChg[3:0], nClr[3:0]}, 12'h111)
    acc(0, `OFS_LATCH, 0, 0);
    `CHK(rdat, 32'h1234_5678)
    counterValue <= 32'h9;
    acc(0, `OFS_LATCH, 0, 0);
    `CHK(rdat, 32'h1234_5678)
    acc(1, `OFS_SENSOR_CFG, 32'h101, 0);
    generalInput <= 1'b1;
    cyc(4);
    `CHK(nStop, 2)
    acc(1, `OFS_SENSOR_CFG, 32'h132, 0);
    axisStatus[3] <= 1'b1;
    cyc(4);
    `CHK(nStop, 3)
    {auxSensorIn, generalInput, axisStatus[3]} <= 3'h0;
    for (i = 0; i < 3; i++) begin
      acc(1, `OFS_OUT_CFG, 32'h50 | i, 0);
      for (j = 0; j < 2; j++) begin
        {counterOut, axisStatus[5], compareResult} <= 3'(1 << i) ^ {3{j[0]}};
        cyc(3);
        `CHK(generalOutput, ~j[0])
      end
    end
    for (i = 1; i < 5; i++) begin
      acc(1, `OFS_SYNC_CFG, 32'h130 | i, 0);
      cyc(3);
      `CHK(nSync, i - 1)
      case (i)
        1: auxSensorIn <= 1'b1;
        2: generalInput <= 1'b1;
        3: axisStatus[3] <= 1'b1;
        default: acc(1, `OFS_PAUSE, 32'h1, 0);
      endcase
      cyc(4);
      `CHK(nSync, i)
      {auxSensorIn, generalInput, axisStatus[3]} <= 3'h0;
    end
    acc(1, `OFS_SYNC_CFG, 32'h100, 0);
    cyc(3);
    `CHK(nSync, 5)
    acc(0, 8'h30, 0, 1);
    `CHK(rdat, 32'h0)
    acc(1, 8'h3c, 32'hffff, 1);
    end_sim();
  end
endmodule // tb_top

bind axis_aux_control axis_aux_control_sva chk (.clk, .reset_n, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .emergencyStopIn,
  .emergencyStop, .positioningDoneIn, .filteredAux, .cmdReady, .cmdValid,
  .syncStart, .sensorStop, .irq);
